// file: bod_sleep_unlock.sv
`timescale 1ns/1ps
// timed two-write unlock for the brown-out sleep disable bit
module bod_sleep_unlock
   import sleep_ctl_pkg::*;
#(
   parameter bit SW_BOD_PRESENT = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic wr_disable,
   input wire logic wr_unlock,
   output logic disable_bit,
   output logic disable_active
);

   logic [2:0] window_ff;
   logic [1:0] hold_ff;
   logic bit_ff;
   logic [2:0] dly_ff;

   wire arm_wr = wr_en && wr_disable && wr_unlock;
   wire commit_wr = wr_en && wr_disable && !wr_unlock && (window_ff != 3'd0);

   // window closes on its own if the second write is late
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         window_ff <= 3'd0;
      end else if (arm_wr) begin
         window_ff <= UNLOCK_WINDOW_CYC;
      end else if (window_ff != 3'd0) begin
         window_ff <= window_ff - 3'd1;
      end
   end

   // bit clears itself three cycles after it is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_ff <= 1'b0;
         hold_ff <= 2'd0;
      end else if (commit_wr) begin
         bit_ff <= 1'b1;
         hold_ff <= BROWNOUT_SLEEP_DISABLE_CLEAR_CYC;
      end else if (hold_ff == 2'd1) begin
         bit_ff <= 1'b0;
         hold_ff <= 2'd0;
      end else if (hold_ff != 2'd0) begin
         hold_ff <= hold_ff - 2'd1;
      end
   end

   // effective copy lags the bit by three cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_ff <= 3'd0;
      end else begin
         dly_ff <= {dly_ff[1:0], bit_ff};
      end
   end

   // without the option both bits are dead
   assign disable_bit = SW_BOD_PRESENT && bit_ff;
   assign disable_active = SW_BOD_PRESENT && dly_ff[2];

endmodule

// file: cpu_core_model.sv
`timescale 1ns/1ps
// core side: issues the sleep instruction and raises the wake request
module cpu_core_model (
   input wire logic pclk,
   input wire logic cpu_halt,
   output logic sleep_instr,
   output logic wake_pin
);
   initial begin
      sleep_instr = 1'b0;
      wake_pin = 1'b0;
   end
   // one-cycle sleep pulse; the caller arms enable and disable bits first
   task automatic do_sleep();
      @(posedge pclk);
      sleep_instr <= 1'b1;
      @(posedge pclk);
      sleep_instr <= 1'b0;
   endtask
   // level request held until the core runs again; n counts cycles to resume
   task automatic wake(output int n);
      @(posedge pclk);
      wake_pin <= 1'b1;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (cpu_halt && n < 3000);
      @(posedge pclk);
      wake_pin <= 1'b0;
   endtask
endmodule

// file: sleep_and_power_gating_control_bench.sv
`timescale 1ns/1ps
module sleep_and_power_gating_control_bench;
   import sleep_ctl_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [APB_AW-1:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sleep_instr;
   logic wake_pin;
   logic ext_crystal_sel = 1'b1;
   logic brownout_level_fuse = 1'b1;
   logic comp_uses_vref = 1'b0;
   clk_gate_t clk_gate;
   logic [3:0] periph_clk_en;
   analog_ctl_t analog_ctl;
   logic cpu_halt;
   logic [31:0] rd_data;
   logic [31:0] prdata_nb;
   logic [31:0] rd_nb;
   logic err;
   int fail_count = 0;
   int check_count = 0;
   always #12.5 pclk = ~pclk;
   // short oscillator start-up keeps the power-down wake quick
   sleep_power_ctl #(.SW_BOD_PRESENT(1'b1), .OSC_START_CYC(12'd2)) i_dut (.*);
   cpu_core_model i_cpu (.*);
   // twin built without the software detector disable; only its read data is watched
   sleep_power_ctl #(.SW_BOD_PRESENT(1'b0), .OSC_START_CYC(12'd2)) i_dut_nobod (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata_nb),
      .pready(),
      .pslverr(),
      .sleep_instr(sleep_instr),
      .wake_pin(wake_pin),
      .ext_crystal_sel(ext_crystal_sel),
      .brownout_level_fuse(brownout_level_fuse),
      .comp_uses_vref(comp_uses_vref),
      .clk_gate(),
      .periph_clk_en(),
      .analog_ctl(),
      .cpu_halt()
   );
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // apb transfer; request stands until pready is seen at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_data = prdata;
      rd_nb = prdata_nb;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // sleep and check the clock enables once the entry edge has landed
   task automatic snooze(input logic [4:0] g);
      i_cpu.do_sleep();
      @(negedge pclk);
      chk("clk_gate", 32'(g), 32'(clk_gate));
      chk("cpu_halt", 32'h0000_0001, 32'(cpu_halt));
   endtask
   // wake; the count allows for the two-flop wake sync and the state step
   task automatic rouse(input int nn);
      int n;
      i_cpu.wake(n);
      chk("wake cycles", 32'h0000_0001, 32'(n >= nn + 2 && n <= nn + 4));
      xfer(1'b1, 8'h00, 32'h0000_0000);
   endtask
   task automatic summarize();
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #(20000 * 25);
      fail_count++;
      summarize();
   end
   // main sequence: registers, timed unlock, then every sleep mode
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      xfer(1'b0, 8'h00, 32'h0000_0000);
      chk("ctl reset", 32'h0000_0000, rd_data);
      xfer(1'b1, 8'h00, 32'h0000_0043);
      xfer(1'b0, 8'h00, 32'h0000_0000);
      chk("loose bits", 32'h0000_0000, rd_data);
      xfer(1'b0, 8'h0C, 32'h0000_0000);
      chk("unmapped", 32'h0000_0001, 32'(err));
      xfer(1'b1, 8'h04, 32'h0000_000A);
      repeat (2) @(negedge pclk);
      chk("gated", 32'h0000_0005, 32'(periph_clk_en));
      xfer(1'b1, 8'h04, 32'h0000_0000);
      repeat (2) @(negedge pclk);
      chk("ungated", 32'h0000_000F, 32'(periph_clk_en));
      xfer(1'b1, 8'h00, 32'h0000_0084);
      repeat (2) @(posedge pclk);
      xfer(1'b1, 8'h00, 32'h0000_0080);
      xfer(1'b0, 8'h00, 32'h0000_0000);
      chk("late unlock", 32'h0000_0000, rd_data);
      xfer(1'b1, 8'h00, 32'h0000_0084);
      xfer(1'b1, 8'h00, 32'h0000_0080);
      xfer(1'b0, 8'h00, 32'h0000_0000);
      chk("disable set", 32'h0000_0080, rd_data);
      chk("no option bit", 32'h0000_0000, rd_nb);
      xfer(1'b0, 8'h00, 32'h0000_0000);
      chk("disable clear", 32'h0000_0000, rd_data);
      xfer(1'b1, 8'h00, 32'h0000_0084);
      xfer(1'b1, 8'h00, 32'h0000_0080);
      xfer(1'b0, 8'h08, 32'h0000_0000);
      chk("not yet effective", 32'h0000_0000, 32'(rd_data[7]));
      xfer(1'b0, 8'h08, 32'h0000_0000);
      chk("effective", 32'h0000_0001, 32'(rd_data[7]));
      chk("no option active", 32'h0000_0000, 32'(rd_nb[7]));
      xfer(1'b1, 8'h00, 32'h0000_00B4);
      xfer(1'b1, 8'h00, 32'h0000_00B0);
      repeat (2) @(posedge pclk);
      snooze(5'h00);
      chk("bod off", 32'h0000_0000, 32'(analog_ctl.bod_en));
      chk("buffers off", 32'h0000_0000, 32'(analog_ctl.input_buf_en));
      rouse(2404);
      chk("bod back", 32'h0000_0001, 32'(analog_ctl.bod_en));
      comp_uses_vref <= 1'b1;
      xfer(1'b1, 8'h00, 32'h0000_0038);
      snooze(5'h01);
      chk("bod kept", 32'h0000_0001, 32'(analog_ctl.bod_en));
      chk("vref kept", 32'h0000_0001, 32'(analog_ctl.vref_en));
      chk("comp off", 32'h0000_0000, 32'(analog_ctl.comparator_en));
      rouse(10);
      xfer(1'b1, 8'h00, 32'h0000_0030);
      snooze(5'h00);
      rouse(6);
      xfer(1'b1, 8'h04, 32'h0000_0001);
      xfer(1'b1, 8'h00, 32'h0000_0020);
      snooze(5'h07);
      chk("idle gating", 32'h0000_000E, 32'(periph_clk_en));
      chk("idle comp", 32'h0000_0001, 32'(analog_ctl.comparator_en));
      rouse(4);
      xfer(1'b1, 8'h04, 32'h0000_0000);
      xfer(1'b1, 8'h00, 32'h0000_0028);
      snooze(5'h03);
      chk("adc buffers", 32'h0000_0001, 32'(analog_ctl.input_buf_en));
      rouse(4);
      ext_crystal_sel <= 1'b0;
      xfer(1'b1, 8'h00, 32'h0000_0038);
      snooze(5'h00);
      rouse(6);
      xfer(1'b1, 8'h00, 32'h0000_0010);
      i_cpu.do_sleep();
      @(negedge pclk);
      chk("no enable", 32'h0000_0000, 32'(cpu_halt));
      summarize();
   end
endmodule

// file: sleep_ctl_pkg.sv
package sleep_ctl_pkg;

   // bus geometry and register offsets
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] CORE_POWER_CONTROL_OFF = 8'h00;
   localparam logic [APB_AW-1:0] PERIPH_GATING_OFF = 8'h04;
   localparam logic [APB_AW-1:0] POWER_STATUS_OFF = 8'h08;

   // field positions in core_power_control
   localparam int BROWNOUT_SLEEP_DISABLE_POS = 7;
   localparam int SLEEP_EN_POS = 5;
   localparam int SM_HI_POS = 4;
   localparam int SM_LO_POS = 3;
   localparam int UNLOCK_POS = 2;

   // reset values
   localparam logic [1:0] SLEEP_MODE_RST = 2'h0;
   localparam logic SLEEP_EN_RST = 1'b0;
   localparam logic [3:0] PERIPH_GATING_RST = 4'h0;

   // peripheral gating bit positions
   localparam int PG_TIM1 = 3;
   localparam int PG_TIM0 = 2;
   localparam int PG_SERIAL = 1;
   localparam int PG_ADC = 0;

   // timed sequence counts, in clock cycles
   localparam logic [2:0] UNLOCK_WINDOW_CYC = 3'd4;
   localparam logic [1:0] BROWNOUT_SLEEP_DISABLE_CLEAR_CYC = 2'd3;

   // wake timing
   localparam int CLK_MHZ = 40;
   localparam int BOD_WAKE_US = 60;
   localparam int BOD_WAKE_CYC_I = BOD_WAKE_US * CLK_MHZ;
   localparam int WDW = 12;
   localparam logic [WDW-1:0] BOD_WAKE_CYC = WDW'(BOD_WAKE_CYC_I);
   localparam logic [WDW-1:0] STANDBY_WAKE_CYC = 12'd6;
   localparam logic [WDW-1:0] INT_HALT_CYC = 12'd4;
   localparam logic [WDW-1:0] OSC_START_CYC_RST = 12'd16;

   typedef enum logic [1:0] {
      MODE_IDLE = 2'b00,
      MODE_ADC_NR = 2'b01,
      MODE_PWR_DOWN = 2'b10,
      MODE_STANDBY = 2'b11
   } sleep_mode_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SLEEP = 2'b01,
      ST_WAKE = 2'b10
   } pwr_state_t;

   // clock domain enables toward the clock tree
   typedef struct packed {
      logic cpu;
      logic flash;
      logic io;
      logic adc;
      logic osc;
   } clk_gate_t;

   // analog and pad controls
   typedef struct packed {
      logic bod_en;
      logic input_buf_en;
      logic comparator_en;
      logic vref_en;
   } analog_ctl_t;

endpackage

// file: sleep_power_ctl.sv
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
module sleep_power_ctl
   import sleep_ctl_pkg::*;
#(
   parameter bit SW_BOD_PRESENT = 1'b1,
   parameter logic [WDW-1:0] OSC_START_CYC = OSC_START_CYC_RST
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_instr,
   input wire logic wake_pin,
   input wire logic ext_crystal_sel,
   input wire logic brownout_level_fuse,
   input wire logic comp_uses_vref,
   output clk_gate_t clk_gate,
   output logic [3:0] periph_clk_en,
   output analog_ctl_t analog_ctl,
   output logic cpu_halt
);

   // ---------------- input synchronisers ----------------
   localparam int NSYNC = 3;
   logic [NSYNC-1:0] sync_in;
   logic [NSYNC-1:0] meta_ff;
   logic [NSYNC-1:0] sync_ff;

   assign sync_in = {brownout_level_fuse, ext_crystal_sel, wake_pin};

   // two flops per asynchronous input; only the second stage is read
   // reset value zero: the fuse reads as detector-off for two edges after reset
   generate
      for (genvar i = 0; i < NSYNC; i++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_ff[i] <= 1'b0;
               sync_ff[i] <= 1'b0;
            end else begin
               meta_ff[i] <= sync_in[i];
               sync_ff[i] <= meta_ff[i];
            end
         end
      end
   endgenerate

   wire wake_req = sync_ff[0];
   wire crystal_sel = sync_ff[1];
   wire fuse_bod_on = sync_ff[2];

   // ---------------- register state ----------------
   logic sleep_en_ff;
   logic [1:0] sleep_mode_ff;
   logic [3:0] gating_ff;
   pwr_state_t state_ff;
   pwr_state_t nxt_state;
   sleep_mode_t active_mode_ff;
   logic bod_off_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   // ---------------- apb decode ----------------
   wire setup_ph = psel && !penable;
   wire access_ph = psel && penable && pready_ff;
   wire hit_ctl = (paddr == CORE_POWER_CONTROL_OFF);
   wire hit_pg = (paddr == PERIPH_GATING_OFF);
   wire hit_stat = (paddr == POWER_STATUS_OFF);
   wire hit_any = hit_ctl || hit_pg || hit_stat;
   wire wr_ctl = access_ph && pwrite && hit_ctl;
   wire wr_pg = access_ph && pwrite && hit_pg;

   // ---------------- timed unlock ----------------
   logic brownout_sleep_disable_bit;
   logic brownout_sleep_disable_active;

   bod_sleep_unlock #(
      .SW_BOD_PRESENT(SW_BOD_PRESENT)
   ) u_unlock (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr_ctl),
      .wr_disable(pwdata[BROWNOUT_SLEEP_DISABLE_POS]),
      .wr_unlock(pwdata[UNLOCK_POS]),
      .disable_bit(brownout_sleep_disable_bit),
      .disable_active(brownout_sleep_disable_active)
   );

   // readback: unlock bit never holds a value, unused bits stay zero
   wire [7:0] ctl_rd = {brownout_sleep_disable_bit, 1'b0, sleep_en_ff, sleep_mode_ff, 3'b000};
   wire [31:0] stat_rd = {24'h00_0000, brownout_sleep_disable_active, bod_off_ff, 2'b00,
                          active_mode_ff, state_ff};
   wire [31:0] rd_mux = hit_ctl ? {24'h00_0000, ctl_rd} :
                        hit_pg ? {28'h000_0000, gating_ff} :
                        hit_stat ? stat_rd : 32'h0000_0000;

   // read data and answer are built in setup, so access is always one cycle
   wire [31:0] nxt_prdata = (setup_ph && !pwrite) ? rd_mux : 32'h0000_0000;
   wire nxt_pslverr = setup_ph && !hit_any;

   // read data drops to zero outside the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else begin
         prdata_ff <= nxt_prdata;
      end
   end

   // wait-free slave: ready follows every setup cycle by one edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= setup_ph;
      end
   end

   // unmapped offsets answer with an error and are otherwise ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_ff <= 1'b0;
      end else begin
         pslverr_ff <= nxt_pslverr;
      end
   end

   // field slices of the write word; only bits 5 and 4:3 are stored here
   wire wr_sleep_en = pwdata[SLEEP_EN_POS];
   wire [1:0] wr_sleep_mode = pwdata[SM_HI_POS:SM_LO_POS];

   // enable bit; left set by software it arms every sleep instruction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_en_ff <= SLEEP_EN_RST;
      end else if (wr_ctl) begin
         sleep_en_ff <= wr_sleep_en;
      end
   end

   // mode field; every code is legal, standby falls back without a crystal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_mode_ff <= SLEEP_MODE_RST;
      end else if (wr_ctl) begin
         sleep_mode_ff <= wr_sleep_mode;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gating_ff <= PERIPH_GATING_RST;
      end else if (wr_pg) begin
         gating_ff <= pwdata[3:0];
      end
   end

   // ---------------- sleep sequencing ----------------
   // sleep instruction without the enable bit is just a no-op
   wire sleep_go = (state_ff == ST_RUN) && sleep_instr && sleep_en_ff;
   // mode 11 only becomes standby with a crystal; otherwise oscillator stops
   wire [1:0] req_mode = (sleep_mode_ff == MODE_STANDBY && !crystal_sel) ?
                         MODE_PWR_DOWN : sleep_mode_ff;
   wire deep_req = (req_mode == MODE_PWR_DOWN) || (req_mode == MODE_STANDBY);
   // disable is sampled at the instant of entry only
   wire bod_off_req = brownout_sleep_disable_active && deep_req;
   wire wake_now = (state_ff == ST_SLEEP) && wake_req;

   // wake delay plumbing
   logic wake_done;
   logic [WDW-1:0] base_delay;
   logic [WDW-1:0] wake_delay;

   // start-up time per mode; idle and noise reduction need none
   always_comb begin
      unique case (active_mode_ff)
         MODE_STANDBY: base_delay = STANDBY_WAKE_CYC;
         MODE_PWR_DOWN: base_delay = OSC_START_CYC;
         default: base_delay = '0;
      endcase
      // detector must settle before code runs
      if (bod_off_ff && base_delay < BOD_WAKE_CYC) begin
         base_delay = BOD_WAKE_CYC;
      end
      wake_delay = base_delay + INT_HALT_CYC;
   end

   // loaded on the wake edge; the cpu is released when it runs out
   wake_delay_timer u_wake (
      .pclk(pclk),
      .presetn(presetn),
      .load(wake_now),
      .load_val(wake_delay),
      .done(wake_done)
   );

   // state transitions
   // a wake request while running is ignored: the level carries no memory
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_RUN: if (sleep_go) nxt_state = ST_SLEEP;
         ST_SLEEP: if (wake_req) nxt_state = ST_WAKE;
         ST_WAKE: if (wake_done) nxt_state = ST_RUN;
         default: nxt_state = ST_RUN;
      endcase
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // mode held for the whole sleep, so wake timing uses what was entered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_mode_ff <= MODE_IDLE;
      end else if (sleep_go) begin
         active_mode_ff <= sleep_mode_t'(req_mode);
      end
   end

   // detector choice sampled at entry only, dropped once running again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bod_off_ff <= 1'b0;
      end else if (sleep_go) begin
         bod_off_ff <= bod_off_req;
      end else if (state_ff == ST_RUN) begin
         bod_off_ff <= 1'b0;
      end
   end

   // ---------------- output decode ----------------
   wire in_sleep = (state_ff == ST_SLEEP) || sleep_go;
   wire [1:0] cur_mode = sleep_go ? req_mode : active_mode_ff;
   wire is_adc_nr = in_sleep && (cur_mode == MODE_ADC_NR);
   wire is_deep = in_sleep && ((cur_mode == MODE_PWR_DOWN) || (cur_mode == MODE_STANDBY));
   wire cur_bod_off = sleep_go ? bod_off_req : bod_off_ff;

   // idle drops cpu/flash, noise reduction also io, power-down everything, standby all but osc
   clk_gate_t nxt_clk;
   assign nxt_clk.cpu = !in_sleep;
   assign nxt_clk.flash = !in_sleep;
   assign nxt_clk.io = !(is_adc_nr || is_deep);
   assign nxt_clk.adc = !is_deep;
   assign nxt_clk.osc = !(is_deep && cur_mode == MODE_PWR_DOWN);

   // gating follows the domain clock, so deep modes stop it regardless
   logic [3:0] nxt_periph;
   generate
      for (genvar p = 0; p < 4; p++) begin : g_periph
         // the converter hangs off its own clock, the others off io
         wire dom_run = (p == PG_ADC) ? nxt_clk.adc : nxt_clk.io;
         assign nxt_periph[p] = dom_run && !gating_ff[p];
      end
   endgenerate

   // detector follows the fuse, dropped only for an armed deep sleep;
   // leaving the sleep state brings it back at once
   analog_ctl_t nxt_analog;
   assign nxt_analog.bod_en = fuse_bod_on && !(in_sleep && cur_bod_off);
   // wake-detect pad buffers sit outside this control
   assign nxt_analog.input_buf_en = nxt_clk.io || nxt_clk.adc;
   assign nxt_analog.comparator_en = !is_deep;
   assign nxt_analog.vref_en = comp_uses_vref || nxt_analog.bod_en;

   // every output is a flop; registering costs one cycle of gating latency
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_gate <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, osc: 1'b1};
      end else begin
         clk_gate <= nxt_clk;
      end
   end

   // peripheral enables come up running so nothing is frozen out of reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_clk_en <= 4'hF;
      end else begin
         periph_clk_en <= nxt_periph;
      end
   end

   // detector output waits for the synchronised fuse, hence off in reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_ctl <= '{bod_en: 1'b0, input_buf_en: 1'b1,
                         comparator_en: 1'b1, vref_en: 1'b0};
      end else begin
         analog_ctl <= nxt_analog;
      end
   end

   // cpu stays halted until the wake delay ends
   wire nxt_cpu_halt = (nxt_state != ST_RUN);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_halt <= 1'b0;
      end else begin
         cpu_halt <= nxt_cpu_halt;
      end
   end

   // bus outputs are the response flops themselves
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;

endmodule

// file: sleep_power_ctl_checker.sv
`timescale 1ns/1ps
// port-level watcher for the power controller; shadows the control writes
module sleep_power_ctl_checker
   import sleep_ctl_pkg::*;
#(
   parameter bit SW_BOD_PRESENT = 1'b1,
   parameter logic [WDW-1:0] OSC_START_CYC = OSC_START_CYC_RST
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic sleep_instr,
   input wire logic ext_crystal_sel,
   input wire logic brownout_level_fuse,
   input wire clk_gate_t clk_gate,
   input wire logic [3:0] periph_clk_en,
   input wire analog_ctl_t analog_ctl,
   input wire logic cpu_halt
);
   logic wr_take;
   logic go;
   logic se_ff;
   logic [1:0] sm_ff;
   logic [3:0] pg_ff;
   logic [1:0] pg_age_ff;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // a completed write, and a sleep request taken while running
   assign wr_take = psel && penable && pready && pwrite;
   assign go = sleep_instr && !cpu_halt && se_ff;
   // field shadow; the age gives the gating outputs time to settle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         se_ff <= 1'b0;
         sm_ff <= 2'b00;
         pg_ff <= 4'h0;
         pg_age_ff <= 2'd0;
      end else begin
         if (wr_take && paddr == CORE_POWER_CONTROL_OFF) begin
            se_ff <= pwdata[SLEEP_EN_POS];
            sm_ff <= pwdata[SM_HI_POS:SM_LO_POS];
         end
         if (wr_take && paddr == PERIPH_GATING_OFF) begin
            pg_ff <= pwdata[3:0];
            pg_age_ff <= 2'd0;
         end else if (pg_age_ff != 2'd3) begin
            pg_age_ff <= pg_age_ff + 2'd1;
         end
      end
   end
   a_sleep_needs_se: assert property (sleep_instr && !cpu_halt && !se_ff |=> !cpu_halt)
      else $error("sleep entered with sleep enable clear");
   a_idle_clocks: assert property (go && sm_ff == 2'b00 |=> clk_gate == 5'h07)
      else $error("idle clock enables wrong");
   a_adc_clocks: assert property (go && sm_ff == 2'b01 |=> clk_gate == 5'h03)
      else $error("noise reduction clock enables wrong");
   a_down_clocks: assert property (go && sm_ff == 2'b10 |=> clk_gate == 5'h00)
      else $error("power-down clock enables wrong");
   a_standby_osc: assert property (go && sm_ff == 2'b11 && ext_crystal_sel |=> clk_gate == 5'h01)
      else $error("standby clock enables wrong");
   a_standby_fallback: assert property (go && sm_ff == 2'b11 && !ext_crystal_sel |=> clk_gate == 5'h00)
      else $error("mode 11 without crystal did not act as power-down");
   a_buf_off: assert property (!clk_gate.io && !clk_gate.adc |-> !analog_ctl.input_buf_en)
      else $error("input buffers on with io and adc clocks stopped");
   a_comp_off: assert property (cpu_halt && !clk_gate.adc |-> !analog_ctl.comparator_en)
      else $error("comparator on in deep sleep");
   a_bod_back: assert property ($rose(clk_gate.cpu) && brownout_level_fuse
      |-> ##[0:1] analog_ctl.bod_en)
      else $error("detector not back on after wake");
   a_resvd_read: assert property (psel && penable && pready && !pwrite && paddr == 8'h00
      |-> prdata[31:8] == 24'h00_0000 && !prdata[6] && prdata[2:0] == 3'h0)
      else $error("loose control bits read nonzero");
   a_gate_apply: assert property (pg_age_ff == 2'd3 && !cpu_halt |-> periph_clk_en == ~pg_ff)
      else $error("peripheral clock enables do not follow gating");
endmodule

bind sleep_power_ctl sleep_power_ctl_checker #(.SW_BOD_PRESENT(SW_BOD_PRESENT),
   .OSC_START_CYC(OSC_START_CYC)) i_chk (.*);

// file: wake_delay_timer.sv
`timescale 1ns/1ps
// one-shot down counter; done pulses after exactly load_val cycles
module wake_delay_timer
   import sleep_ctl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [WDW-1:0] load_val,
   output logic done
);

   logic [WDW-1:0] cnt_ff;

   // a zero load is treated as one cycle so done always fires
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= '0;
      end else if (load) begin
         cnt_ff <= (load_val == '0) ? WDW'(1) : load_val;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - WDW'(1);
      end
   end

   assign done = (cnt_ff == WDW'(1)) && !load;

endmodule
